// ===== rtl/i2cst_params.svh
`ifndef I2CST_PARAMS_SVH
`define I2CST_PARAMS_SVH

// Register byte offsets
`define I2CST_OFF_OWN   8'h00
`define I2CST_OFF_CTRL  8'h04
`define I2CST_OFF_STAT  8'h08
`define I2CST_OFF_DATA  8'h0C
`define I2CST_OFF_IST   8'h10
`define I2CST_OFF_IMSK  8'h14

// Control register fields
`define I2CST_CTL_FLAG  7
`define I2CST_CTL_ACK   6
`define I2CST_CTL_STA   5
`define I2CST_CTL_STO   4
`define I2CST_CTL_EN    2

// Interrupt status fields
`define I2CST_IRQ_STEP  0
`define I2CST_IRQ_END   1
`define I2CST_IRQ_WAKE  2
`define I2CST_IRQ_W     3

// Status codes, prescaler bits zero
`define I2CST_SC_IDLE   8'hF8
`define I2CST_SC_SRW    8'h60
`define I2CST_SC_SRWAL  8'h68
`define I2CST_SC_GC     8'h70
`define I2CST_SC_A8     8'hA8
`define I2CST_SC_B0     8'hB0
`define I2CST_SC_B8     8'hB8
`define I2CST_SC_C0     8'hC0
`define I2CST_SC_C8     8'hC8

// Reset values, general call address, last bit count
`define I2CST_RST_OWN   8'h00
`define I2CST_RST_DATA  8'hFF
`define I2CST_GC_ADDR   7'h00
`define I2CST_LAST_BIT  3'h7

`endif

// ===== rtl/i2cst_pkg.sv
package i2cst_pkg;
    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_AACK, S_WAIT, S_TX, S_RACK, S_IGN
    } i2cst_state_e;

    typedef struct packed {
        logic [7:0] a;
        logic       w;
    } i2cst_acc_s;

    typedef struct packed {
        logic scl;
        logic sda;
    } i2cst_pins_s;
endpackage

// ===== rtl/i2cst_slave_tx.sv
// Function
// - Answer own seven-bit address, and general call when enabled
// - General call answered when address LSB set
// - Read bit gives transmit, write gives code 60, 68 or 70, then the bus is ignored
// - Own address read: flag and code A8
// - After lost arbitration, own address read reports code B0 (write gives 68)
// - Acknowledge cleared: last byte, C0 or C8
// - After last byte release data, idle slave
// - Acknowledged final byte reports code C8
// - Acknowledge clear ignores address, bus still watched
// - Deep sleep: match wakes, clock held low
// - Data register not trusted after wake
// - Software loads byte, clears flag, byte sent
// - NACK reports C0, then not addressed
// - From C8, clearing flag leaves addressed state
// - Start request then START once bus free
`include "i2cst_params.svh"
module i2cst_slave_tx
    import i2cst_pkg::*;
#(
    parameter int unsigned HADDR_W = 32
) (
    input  wire logic               clk,        // System clock
    input  wire logic               resetn,     // Async reset, low
    input  wire logic               hsel,       // AHB select
    input  wire logic [HADDR_W-1:0] haddr,      // AHB address
    input  wire logic [1:0]         htrans,     // AHB transfer type
    input  wire logic               hwrite,     // AHB write
    input  wire logic [2:0]         hsize,      // AHB size
    input  wire logic [31:0]        hwdata,     // AHB write data
    input  wire logic               hready,     // AHB bus ready
    output logic                    hreadyout,  // AHB slave ready
    output logic                    hresp,      // AHB response
    output logic [31:0]             hrdata,     // AHB read data
    input  wire logic               scl_i,      // Bus clock in
    output logic                    scl_o,      // Bus clock out
    output logic                    scl_oe,     // Bus clock pull low
    input  wire logic               sda_i,      // Bus data in
    output logic                    sda_o,      // Bus data out
    output logic                    sda_oe,     // Bus data pull low
    input  wire logic               arb_lost,   // Master lost arbitration
    input  wire logic               deep_sleep, // Non-idle sleep active
    output logic                    wake,       // Wake request pulse
    output logic                    start_gen,  // START request pulse
    output logic                    irq         // Interrupt level
);

    generate
        if (HADDR_W < 8) begin : g_chk
            $error("HADDR_W must be at least 8");
        end
    endgenerate

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction

    ////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: writes zero wait, reads one wait state

    i2cst_acc_s acc;
    logic       acc_v;
    logic       rd_pend;
    logic       wr_en;
    logic [31:0] rd_mux;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc   <= '0;
            acc_v <= 1'b0;
        end else if (hready) begin
            acc_v <= hsel && htrans[1];
            acc   <= '{a: haddr[7:0], w: hwrite};
        end
    end

    // Registered read data keeps hrdata off the decode path
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_pend <= 1'b0;
            hrdata  <= 32'h0000_0000;
        end else begin
            rd_pend <= hsel && htrans[1] && hready && !hwrite;
            if (rd_pend) begin
                hrdata <= rd_mux;
            end
        end
    end

    assign hreadyout = !rd_pend;
    assign hresp     = 1'b0;
    assign wr_en     = acc_v && acc.w && !rd_pend;

    ////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0] own_address_reg;
    logic [7:0] data_reg;
    logic [7:0] code;
    logic [1:0] presc;
    logic       interrupt_flag;
    logic       ack_enable;
    logic       start_request;
    logic       stop_request;
    logic       interface_enable;
    logic [`I2CST_IRQ_W-1:0] ist;
    logic [`I2CST_IRQ_W-1:0] imask;
    logic       hw_set;
    logic       flag_clr;
    logic       end_evt;
    logic [6:0] own_slave_address;
    logic       general_call_enable;

    assign own_slave_address   = own_address_reg[7:1];
    assign general_call_enable = own_address_reg[0];
    assign flag_clr = wr_en && hit(acc.a, `I2CST_OFF_CTRL)
                      && hwdata[`I2CST_CTL_FLAG];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            own_address_reg  <= `I2CST_RST_OWN;
            data_reg         <= `I2CST_RST_DATA;
            presc            <= 2'h0;
            ack_enable       <= 1'b0;
            start_request    <= 1'b0;
            stop_request     <= 1'b0;
            interface_enable <= 1'b0;
            imask            <= '0;
        end else if (wr_en) begin
            if (hit(acc.a, `I2CST_OFF_OWN)) begin
                own_address_reg <= hwdata[7:0];
            end
            if (hit(acc.a, `I2CST_OFF_CTRL)) begin
                ack_enable       <= hwdata[`I2CST_CTL_ACK];
                start_request    <= hwdata[`I2CST_CTL_STA];
                stop_request     <= hwdata[`I2CST_CTL_STO];
                interface_enable <= hwdata[`I2CST_CTL_EN];
            end
            if (hit(acc.a, `I2CST_OFF_STAT)) begin
                presc <= hwdata[1:0];
            end
            if (hit(acc.a, `I2CST_OFF_DATA)) begin
                data_reg <= hwdata[7:0];
            end
            if (hit(acc.a, `I2CST_OFF_IMSK)) begin
                imask <= hwdata[`I2CST_IRQ_W-1:0];
            end
        end
    end

    // Hardware set beats a clear in the same cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            interrupt_flag <= 1'b0;
        end else if (hw_set) begin
            interrupt_flag <= 1'b1;
        end else if (flag_clr) begin
            interrupt_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ist <= '0;
        end else begin
            ist <= (ist & ~((wr_en && hit(acc.a, `I2CST_OFF_IST))
                            ? hwdata[`I2CST_IRQ_W-1:0]
                            : '0))
                   | {wake, end_evt, hw_set};
        end
    end

    assign irq = |(ist & imask);

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit(acc.a, `I2CST_OFF_OWN)) begin
            rd_mux[7:0] = own_address_reg;
        end else if (hit(acc.a, `I2CST_OFF_CTRL)) begin
            rd_mux[7:0] = {interrupt_flag, ack_enable, start_request,
                           stop_request, 1'b0, interface_enable, 2'b00};
        end else if (hit(acc.a, `I2CST_OFF_STAT)) begin
            rd_mux[7:0] = {code[7:3], 1'b0, presc};
        end else if (hit(acc.a, `I2CST_OFF_DATA)) begin
            rd_mux[7:0] = data_reg;
        end else if (hit(acc.a, `I2CST_OFF_IST)) begin
            rd_mux[`I2CST_IRQ_W-1:0] = ist;
        end else if (hit(acc.a, `I2CST_OFF_IMSK)) begin
            rd_mux[`I2CST_IRQ_W-1:0] = imask;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers and bus condition detection

    i2cst_pins_s p_q1;
    i2cst_pins_s p_q2;
    i2cst_pins_s p_d;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;
    logic        busy;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            p_q1 <= '1;
            p_q2 <= '1;
            p_d  <= '1;
        end else begin
            p_q1 <= '{scl: scl_i, sda: sda_i};
            p_q2 <= p_q1;
            p_d  <= p_q2;
        end
    end

    assign scl_rise  = p_q2.scl && !p_d.scl;
    assign scl_fall  = !p_q2.scl && p_d.scl;
    assign start_det = p_q2.scl && p_d.scl && p_d.sda && !p_q2.sda;
    assign stop_det  = p_q2.scl && p_d.scl && !p_d.sda && p_q2.sda;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy <= 1'b0;
        end else if (start_det) begin
            busy <= 1'b1;
        end else if (stop_det) begin
            busy <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Slave transmitter state machine

    i2cst_state_e state;
    logic [7:0]   sh;
    logic [2:0]   cnt;
    logic         sda_drv;
    logic         last;
    logic         got_ack;
    logic         arb_seen;
    logic         match;
    logic         is_tx;
    logic         final_code;
    logic         addr_full;

    // Acknowledge enable gates both address kinds
    assign match = interface_enable && ack_enable
                   && ((sh[7:1] == own_slave_address)
                       || (general_call_enable && !sh[0]
                           && sh[7:1] == `I2CST_GC_ADDR));
    assign hw_set = scl_fall
                    && (state == S_AACK || state == S_RACK);
    assign is_tx = code == `I2CST_SC_A8 || code == `I2CST_SC_B0
                   || code == `I2CST_SC_B8;
    assign final_code = code == `I2CST_SC_C0
                        || code == `I2CST_SC_C8;
    assign end_evt = hw_set && state == S_RACK && (!got_ack || last);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state   <= S_IDLE;
            sh      <= 8'h00;
            cnt     <= 3'h0;
            sda_drv <= 1'b0;
            last    <= 1'b0;
            got_ack <= 1'b0;
            code    <= `I2CST_SC_IDLE;
            addr_full <= 1'b0;
        end else if (!interface_enable) begin
            state   <= S_IDLE;
            sda_drv <= 1'b0;
        end else if (start_det && state != S_WAIT) begin
            state   <= S_ADDR;
            cnt     <= 3'h0;
            sda_drv <= 1'b0;
            addr_full <= 1'b0;
        end else if (stop_det) begin
            state   <= S_IDLE;
            sda_drv <= 1'b0;
        end else begin
            case (state)
                S_ADDR: begin
                    if (scl_rise) begin
                        sh        <= {sh[6:0], p_q2.sda};
                        cnt       <= cnt + 3'h1;
                        addr_full <= cnt == `I2CST_LAST_BIT;
                    end
                    // Eighth bit in; decide on its falling edge
                    if (scl_fall && addr_full) begin
                        addr_full <= 1'b0;
                        if (match) begin
                            sda_drv <= 1'b1;
                            state   <= S_AACK;
                        end else begin
                            state <= S_IGN;
                        end
                    end
                end
                S_AACK: begin
                    if (scl_fall) begin
                        sda_drv <= 1'b0;
                        state   <= S_WAIT;
                        if (sh[0]) begin
                            code <= arb_seen ? `I2CST_SC_B0
                                             : `I2CST_SC_A8;
                        end else if (sh[7:1] == `I2CST_GC_ADDR) begin
                            code <= `I2CST_SC_GC;
                        end else begin
                            code <= arb_seen ? `I2CST_SC_SRWAL
                                             : `I2CST_SC_SRW;
                        end
                    end
                end
                S_WAIT: begin
                    if (!interrupt_flag) begin
                        if (is_tx) begin
                            // Byte comes from software, never the bus
                            sh      <= data_reg;
                            sda_drv <= !data_reg[7];
                            last    <= !ack_enable;
                            cnt     <= 3'h0;
                            state   <= S_TX;
                        end else begin
                            state <= S_IGN;
                        end
                    end
                end
                S_TX: begin
                    if (scl_fall) begin
                        if (cnt == `I2CST_LAST_BIT) begin
                            sda_drv <= 1'b0;
                            state   <= S_RACK;
                        end else begin
                            sda_drv <= !sh[6];
                            sh      <= {sh[6:0], 1'b1};
                            cnt     <= cnt + 3'h1;
                        end
                    end
                end
                S_RACK: begin
                    if (scl_rise) begin
                        got_ack <= !p_q2.sda;
                    end
                    if (scl_fall) begin
                        state <= S_WAIT;
                        if (!got_ack) begin
                            code <= `I2CST_SC_C0;
                        end else if (last) begin
                            code <= `I2CST_SC_C8;
                        end else begin
                            code <= `I2CST_SC_B8;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Arbitration memory, START request, wake

    logic start_pend;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            arb_seen <= 1'b0;
        end else if (arb_lost) begin
            arb_seen <= 1'b1;
        end else if (hw_set && state == S_AACK) begin
            arb_seen <= 1'b0;
        end
    end

    // Request waits for the bus to go free
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            start_pend <= 1'b0;
            start_gen  <= 1'b0;
        end else begin
            start_gen <= start_pend && !busy;
            if (state == S_WAIT && !interrupt_flag && final_code
                && start_request) begin
                start_pend <= 1'b1;
            end else if (start_pend && !busy) begin
                start_pend <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wake <= 1'b0;
        end else begin
            wake <= hw_set && state == S_AACK && deep_sleep;
        end
    end

    // Open-drain pins: only ever pull low
    assign scl_o  = 1'b0;
    assign sda_o  = 1'b0;
    assign scl_oe = state == S_WAIT && interrupt_flag;
    assign sda_oe = sda_drv;

    ////////////////////////////////////////////////////////////////////
    // Assertions

    a_stretch_flag: assert property (@(posedge clk) disable iff (!resetn)
        $rose(interrupt_flag) |-> scl_oe)
        else $error("clock not held while flag set");
    a_ack_needs_ea: assert property (@(posedge clk) disable iff (!resetn)
        $rose(state == S_AACK) |-> $past(ack_enable))
        else $error("address acknowledged with ack disabled");
    a_ack_own_addr: assert property (@(posedge clk) disable iff (!resetn)
        $rose(state == S_AACK) |-> sh[7:1] == own_slave_address
        || (general_call_enable && sh[7:1] == 7'h00 && !sh[0]))
        else $error("acknowledged a foreign address");
    a_code_a8: assert property (@(posedge clk) disable iff (!resetn)
        hw_set && state == S_AACK && sh[0] && !arb_seen && !arb_lost
        |=> code == `I2CST_SC_A8 && interrupt_flag)
        else $error("own read not reported as A8");
    a_code_b0: assert property (@(posedge clk) disable iff (!resetn)
        hw_set && state == S_AACK && sh[0] && arb_seen
        |=> code == `I2CST_SC_B0)
        else $error("lost arbitration read not B0");
    a_code_rx: assert property (@(posedge clk) disable iff (!resetn)
        hw_set && state == S_AACK && !sh[0]
        |=> code != `I2CST_SC_A8 && code != `I2CST_SC_B0)
        else $error("write direction entered transmit");
    a_nack_c0: assert property (@(posedge clk) disable iff (!resetn)
        hw_set && state == S_RACK && !got_ack
        |=> code == `I2CST_SC_C0 && scl_oe)
        else $error("nack not reported as C0");
    a_last_c8: assert property (@(posedge clk) disable iff (!resetn)
        hw_set && state == S_RACK && got_ack && last
        |=> code == `I2CST_SC_C8)
        else $error("acked last byte not C8");
    a_release_end: assert property (@(posedge clk) disable iff (!resetn)
        state == S_WAIT && !interrupt_flag && final_code && !start_det
        && !stop_det && interface_enable
        |=> state == S_IGN ##1 !sda_oe)
        else $error("bus not released after last byte");
    a_start_free: assert property (@(posedge clk) disable iff (!resetn)
        start_gen |-> !$past(busy) && !$past(start_gen))
        else $error("start requested on busy bus");
    c_read_addr: cover property (@(posedge clk) disable iff (!resetn)
        $rose(state == S_AACK) ##[1:200] code == `I2CST_SC_A8);
    c_byte_ack: cover property (@(posedge clk) disable iff (!resetn)
        hw_set && state == S_RACK && got_ack && !last);
    c_last_c8: cover property (@(posedge clk) disable iff (!resetn)
        $rose(code == `I2CST_SC_C8));
    c_wake: cover property (@(posedge clk) disable iff (!resetn) wake);

endmodule

// ===== tb/i2cst_master_model.sv
module i2cst_master_model (
    input  wire logic clk,    // System clock
    input  wire logic scl,    // Bus clock line
    input  wire logic sda,    // Bus data line
    output logic      scl_oe, // Pull clock low
    output logic      sda_oe, // Pull data low
    output logic      hung    // Stretch wait ran out
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
        hung   = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Half of the 400 ns link period
    task automatic half();
        repeat (4) @(posedge clk);
    endtask

    // Data changes only while the clock is low
    task automatic bit_io(input logic b, output logic r);
        int n;
        sda_oe <= !b;
        half();
        scl_oe <= 1'b0;
        n = 0;
        @(posedge clk);
        // Slave may stretch while software answers
        while (scl !== 1'b1 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        if (n == 20000)
            hung <= 1'b1;
        half();
        r = sda;
        scl_oe <= 1'b1;
    endtask

    // Bus assumed idle on entry
    task automatic start();
        sda_oe <= 1'b1;
        half();
        scl_oe <= 1'b1;
    endtask

    task automatic stop();
        sda_oe <= 1'b1;
        half();
        scl_oe <= 1'b0;
        half();
        sda_oe <= 1'b0;
        half();
    endtask

    task automatic send(input logic [7:0] d, output logic ack_n);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, ack_n);
    endtask

    task automatic recv(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(!ack, r);
    endtask
endmodule

// ===== tb/tb_i2c_slave_transmitter.sv
`include "i2cst_params.svh"
`define CHK(nm, e, g) \
    begin \
        check_count++; \
        if ((g) !== (e)) begin \
            mismatches++; \
            $display("[ERR] %s exp %h got %h", nm, e, g); \
        end \
    end
module tb_i2c_slave_transmitter;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout, hresp;
    logic [31:0] hrdata;
    logic        scl_o, scl_oe, sda_o, sda_oe, m_scl_oe, m_sda_oe, hung;
    logic        arb_lost = 1'b0;
    logic        deep_sleep = 1'b0;
    logic        wake, start_gen, irq;
    wire         scl = !(scl_oe | m_scl_oe);
    wire         sda = !(sda_oe | m_sda_oe);
    int          mismatches = 0;
    int          check_count = 0;
    int          sg_cnt = 0;
    int          wk_cnt = 0;
    logic [7:0]  b;
    logic        a;

    always #25 clk = ~clk;

    always @(posedge clk) begin
        sg_cnt <= sg_cnt + int'(start_gen);
        wk_cnt <= wk_cnt + int'(wake);
    end

    i2cst_slave_tx i_i2cst_slave_tx (
        .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .scl_i(scl), .scl_o(scl_o),
        .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .arb_lost(arb_lost), .deep_sleep(deep_sleep), .wake(wake),
        .start_gen(start_gen), .irq(irq)
    );

    i2cst_master_model i_i2cst_master_model (
        .clk(clk), .scl(scl), .sda(sda), .scl_oe(m_scl_oe),
        .sda_oe(m_sda_oe), .hung(hung)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 100) begin
                mismatches++;
                end_sim();
            end
            @(posedge clk);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] ad,
                       input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, ad};
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
        `CHK("hresp", 1'b0, hresp)
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, ad, {24'h0, d}, q);
    endtask

    task automatic chk_reg(input logic [7:0] ad, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, ad, 32'h0, q);
        `CHK("register", {24'h0, e}, q)
    endtask

    // Status compared with prescaler bits masked off
    task automatic wait_flag(input logic [7:0] code);
        logic [31:0] q;
        int n;
        n = 0;
        q = 32'h0;
        while (q[`I2CST_CTL_FLAG] !== 1'b1) begin
            n++;
            if (n > 3000) begin
                mismatches++;
                end_sim();
            end
            bus(1'b0, `I2CST_OFF_CTRL, 32'h0, q);
        end
        bus(1'b0, `I2CST_OFF_STAT, 32'h0, q);
        `CHK("status", code, q[7:0] & 8'hF8)
    endtask

    task automatic addr_try(input logic [7:0] ad, input logic e);
        i_i2cst_master_model.start();
        i_i2cst_master_model.send(ad, a);
        `CHK("address ack", e, a)
    endtask

    // Ack enable cleared on load: byte goes out as the last one
    task automatic last_byte(input logic [7:0] d, input logic ack,
                             input logic [7:0] code);
        wr(`I2CST_OFF_DATA, d);
        wr(`I2CST_OFF_CTRL, 8'h84);
        i_i2cst_master_model.recv(ack, b);
        `CHK("last byte", d, b)
        wait_flag(code);
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk_reg(`I2CST_OFF_OWN, `I2CST_RST_OWN);
        chk_reg(`I2CST_OFF_CTRL, 8'h00);
        chk_reg(`I2CST_OFF_STAT, `I2CST_SC_IDLE);
        chk_reg(`I2CST_OFF_DATA, `I2CST_RST_DATA);
        chk_reg(8'h18, 8'h00);
    endtask

    task automatic t_ignore();
        wr(`I2CST_OFF_OWN, 8'h5A);
        wr(`I2CST_OFF_CTRL, 8'h04);
        addr_try(8'h5B, 1'b1);
        i_i2cst_master_model.stop();
        wr(`I2CST_OFF_CTRL, 8'h44);
        addr_try(8'h5D, 1'b1);
        i_i2cst_master_model.stop();
        addr_try(8'h00, 1'b1);
        i_i2cst_master_model.stop();
        wr(`I2CST_OFF_OWN, 8'h5B);
        addr_try(8'h00, 1'b0);
        wait_flag(`I2CST_SC_GC);
        wr(`I2CST_OFF_CTRL, 8'hC4);
        i_i2cst_master_model.stop();
    endtask

    task automatic t_read();
        wr(`I2CST_OFF_IMSK, 8'h02);
        addr_try(8'h5B, 1'b0);
        wait_flag(`I2CST_SC_A8);
        `CHK("scl held", 1'b0, scl)
        wr(`I2CST_OFF_DATA, 8'hA5);
        chk_reg(`I2CST_OFF_DATA, 8'hA5);
        wr(`I2CST_OFF_CTRL, 8'hC4);
        i_i2cst_master_model.recv(1'b1, b);
        `CHK("data byte", 8'hA5, b)
        wait_flag(`I2CST_SC_B8);
        last_byte(8'h3C, 1'b1, `I2CST_SC_C8);
        `CHK("irq", 1'b1, irq)
        wr(`I2CST_OFF_IST, 8'h02);
        @(posedge clk);
        `CHK("irq", 1'b0, irq)
        wr(`I2CST_OFF_CTRL, 8'hE4);
        i_i2cst_master_model.recv(1'b0, b);
        `CHK("released", 8'hFF, b)
        i_i2cst_master_model.stop();
        for (int n = 0; n < 50 && sg_cnt == 0; n++)
            @(posedge clk);
        `CHK("start gen", 1, sg_cnt)
    endtask

    task automatic t_nack();
        arb_lost <= 1'b1;
        @(posedge clk);
        arb_lost <= 1'b0;
        addr_try(8'h5B, 1'b0);
        wait_flag(`I2CST_SC_B0);
        last_byte(8'h81, 1'b0, `I2CST_SC_C0);
        wr(`I2CST_OFF_CTRL, 8'hC4);
        i_i2cst_master_model.stop();
    endtask

    task automatic t_sleep();
        deep_sleep <= 1'b1;
        addr_try(8'h5B, 1'b0);
        wait_flag(`I2CST_SC_A8);
        `CHK("wake", 1, wk_cnt)
        `CHK("scl held", 1'b0, scl)
        deep_sleep <= 1'b0;
        last_byte(8'h42, 1'b0, `I2CST_SC_C0);
        wr(`I2CST_OFF_CTRL, 8'hC4);
        i_i2cst_master_model.stop();
    endtask

    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_ignore();
        t_read();
        t_nack();
        t_sleep();
        `CHK("stretch", 1'b0, hung)
        end_sim();
    end
endmodule
